/* File: atsc_pkg.sv */
// Constants shared by the AT system control port logic
package atsc_pkg;
    localparam int IO_AW = 16;
    localparam int DW = 8;

    // I/O port addresses
    localparam logic [15:0] KBC_DATA_ADDR = 16'h0060;
    localparam logic [15:0] KBC_AUX_ADDR = 16'h0062;
    localparam logic [15:0] KBC_CMD_ADDR = 16'h0064;
    localparam logic [15:0] NMI_STAT_ADDR = 16'h0061;
    localparam logic [15:0] RTC_IDX_ADDR = 16'h0070;
    localparam logic [15:0] FAST_PORT_ADDR = 16'h0092;

    // Status and control port fields
    localparam int ST_PAR_DIS = 2;
    localparam int ST_CHK_DIS = 3;
    localparam int ST_REFRESH = 4;
    localparam int ST_TIMER2 = 5;
    localparam int ST_CHK_FLAG = 6;
    localparam int ST_PAR_FLAG = 7;
    localparam logic ST_PAR_DIS_RST = 1'b0;
    localparam logic ST_CHK_DIS_RST = 1'b0;

    // RTC index port fields
    localparam int RTC_IDX_MSB = 6;
    localparam int RTC_NMI_BLK = 7;
    localparam logic [6:0] RTC_IDX_RST = 7'h00;
    localparam logic NMI_BLK_RST = 1'b1;

    // Fast A20 / reset port fields
    localparam int FP_RESET = 0;
    localparam int FP_A20 = 1;
    localparam logic [7:0] FAST_PORT_RST = 8'h00;

    // Timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int FR_DELAY_NS = 6720;
    localparam int FR_PULSE_MAX_NS = 150;
    localparam int FR_DELAY_CYC = (FR_DELAY_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
    localparam int FR_PULSE_CYC = (FR_PULSE_MAX_NS / CLK_PERIOD_NS) < 1
                                  ? 1 : (FR_PULSE_MAX_NS / CLK_PERIOD_NS);
    localparam int FR_CNT_W = 8;

    typedef enum logic [2:0] {
        FR_IDLE = 3'b001,
        FR_WAIT = 3'b010,
        FR_FIRE = 3'b100
    } atsc_fr_state_e;
endpackage

/* File: atsc_rst_if.sv */
// Trigger and pulse between the port logic and the fast reset timer
interface atsc_rst_if;
    logic trig;
    logic fire;
    modport ctl (output trig, input fire);
    modport gen (input trig, output fire);
endinterface

/* File: atsc_err_latch.sv */
// Sticky error flag with an enable that also clears it
module atsc_err_latch (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic sample_en,
    input wire logic err_n,
    output logic flag_q
);
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            flag_q <= 1'b0;
        end else if (!sample_en) begin
            flag_q <= 1'b0;
        end else if (!err_n) begin
            flag_q <= 1'b1;
        end
    end

    a_flag_sets: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        (sample_en && !err_n) |=> flag_q)
        else $error("error flag not set on sampled error");
    a_flag_holds: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        (flag_q && sample_en) |=> flag_q)
        else $error("error flag dropped while sampling enabled");
    a_flag_clears: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        !sample_en |=> !flag_q)
        else $error("error flag kept while sampling disabled");
endmodule

/* File: atsc_rst_pulse.sv */
// Delayed fixed-width CPU reset pulse generator
module atsc_rst_pulse
    import atsc_pkg::*;
#(
    parameter int DELAY_CYC = FR_DELAY_CYC,
    parameter int PULSE_CYC = FR_PULSE_CYC
) (
    input wire logic clk_sys,
    input wire logic rstn,
    atsc_rst_if.gen rif
);
    atsc_fr_state_e state_q;
    logic [FR_CNT_W-1:0] cnt_q;

    // Fire is registered here and again at the top, so the wait is two short
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_q <= FR_IDLE;
            cnt_q <= '0;
            rif.fire <= 1'b0;
        end else begin
            case (state_q)
                FR_IDLE: begin
                    rif.fire <= 1'b0;
                    if (rif.trig) begin
                        state_q <= FR_WAIT;
                        cnt_q <= FR_CNT_W'(DELAY_CYC - 2);
                    end
                end
                FR_WAIT: begin
                    if (cnt_q == '0) begin
                        state_q <= FR_FIRE;
                        rif.fire <= 1'b1;
                        cnt_q <= FR_CNT_W'(PULSE_CYC - 1);
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                FR_FIRE: begin
                    if (cnt_q == '0) begin
                        state_q <= FR_IDLE;
                        rif.fire <= 1'b0;
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                default: begin
                    state_q <= FR_IDLE;
                    rif.fire <= 1'b0;
                end
            endcase
        end
    end

    a_pulse_width: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        $rose(rif.fire) |=> !rif.fire)
        else $error("fast reset pulse wider than one cycle");
endmodule

/* File: atsc_ports.sv */
// AT system control ports: status/NMI, RTC index, fast A20/reset, KBC glue
// How it works
// - KBC select for ports 60h, 62h, 64h
// - KBC output-full drives IRQ1
// - Merge KBC A20 and reset with fast port
// - Status bit 2 disables parity, ORed override
// - Status bit 3 disables channel check
// - Status bit 4 toggles per refresh
// - Status bit 5 shows timer 2 output
// - Channel check error sets sticky bit 6
// - Parity error sets sticky bit 7
// - Port 70h bit 7 masks NMI
// - NMI disabled after power-up
// - Fast port only when enable bit set
// - Fast port at 92h, resets to 00h
// - Fast port bit 1 clamps A20 low
// - Bit 0 rise gives delayed reset pulse
// - One pulse per bit 0 setting
// - Bit 0 keeps reading set after reset
module atsc_ports
    import atsc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [IO_AW-1:0] io_addr,
    input wire logic [DW-1:0] io_wdata,
    input wire logic io_write_n,
    input wire logic io_read_n,
    output logic [DW-1:0] io_rdata_q,
    output logic io_rdata_oe_q,
    input wire logic fast_port_enable,
    input wire logic parity_check_override,
    input wire logic parity_error_in_n,
    input wire logic channel_check_in_n,
    input wire logic refresh_cycle,
    input wire logic timer2_out,
    input wire logic kbc_output_full,
    input wire logic kbc_a20_clamp_n,
    input wire logic kbc_cpu_reset,
    output logic kbc_select_n,
    output logic irq1_q,
    output logic a20_clamp_n,
    output logic cpu_reset_out,
    output logic nmi_out_q,
    output logic [6:0] rtc_index_q
);
    // Second quiet edge after the commit edge to the first edge that samples the timer's fire high
    localparam int A_DLY = FR_DELAY_CYC - 1;

    logic io_write_n_q;
    logic [IO_AW-1:0] wr_addr_q;
    logic [DW-1:0] wr_data_q;
    logic wr_commit;
    logic par_dis_q;
    logic chk_dis_q;
    logic refresh_q;
    logic nmi_blk_q;
    logic [1:0] fast_q;
    logic chk_flag;
    logic par_flag;
    logic par_en;
    logic chk_en;
    logic wr_stat;
    logic wr_rtc;
    logic wr_fast;
    logic kbc_hit;
    logic [DW-1:0] rd_mux;
    logic rd_hit;

    atsc_rst_if rif ();

    // Writes take effect on the trailing edge of the write strobe; address
    // and data are captured while it is low so late bus changes are harmless
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            io_write_n_q <= 1'b1;
        end else begin
            io_write_n_q <= io_write_n;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wr_addr_q <= '0;
            wr_data_q <= '0;
        end else if (!io_write_n) begin
            wr_addr_q <= io_addr;
            wr_data_q <= io_wdata;
        end
    end

    assign wr_commit = io_write_n && !io_write_n_q;
    assign wr_stat = wr_commit && (wr_addr_q == NMI_STAT_ADDR);
    assign wr_rtc = wr_commit && (wr_addr_q == RTC_IDX_ADDR);
    assign wr_fast = wr_commit && (wr_addr_q == FAST_PORT_ADDR)
                     && fast_port_enable;

    // Status and control port: only the two disable bits are writable
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            par_dis_q <= ST_PAR_DIS_RST;
            chk_dis_q <= ST_CHK_DIS_RST;
        end else if (wr_stat) begin
            par_dis_q <= wr_data_q[ST_PAR_DIS];
            chk_dis_q <= wr_data_q[ST_CHK_DIS];
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            refresh_q <= 1'b0;
        end else if (refresh_cycle) begin
            refresh_q <= !refresh_q;
        end
    end

    assign par_en = !(par_dis_q || parity_check_override);
    assign chk_en = !chk_dis_q;

    atsc_err_latch u_chk_latch (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .sample_en(chk_en),
        .err_n(channel_check_in_n),
        .flag_q(chk_flag)
    );

    atsc_err_latch u_par_latch (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .sample_en(par_en),
        .err_n(parity_error_in_n),
        .flag_q(par_flag)
    );

    // RTC index and NMI mask; NMI starts masked so no stale flag fires early
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rtc_index_q <= RTC_IDX_RST;
            nmi_blk_q <= NMI_BLK_RST;
        end else if (wr_rtc) begin
            rtc_index_q <= wr_data_q[RTC_IDX_MSB:0];
            nmi_blk_q <= wr_data_q[RTC_NMI_BLK];
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            nmi_out_q <= 1'b0;
        end else begin
            nmi_out_q <= !nmi_blk_q && (chk_flag || par_flag);
        end
    end

    // Fast A20 / reset port; only two bits are stored
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            fast_q <= FAST_PORT_RST[1:0];
        end else if (wr_fast) begin
            fast_q <= {wr_data_q[FP_A20], wr_data_q[FP_RESET]};
        end
    end

    // A new pulse needs a 0 to 1 change of the stored reset bit
    assign rif.trig = wr_fast && !fast_q[FP_RESET]
                      && wr_data_q[FP_RESET];

    atsc_rst_pulse #(
        .DELAY_CYC(FR_DELAY_CYC),
        .PULSE_CYC(FR_PULSE_CYC)
    ) u_rst_pulse (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .rif(rif.gen)
    );

    // Keyboard controller glue
    assign kbc_hit = (io_addr == KBC_DATA_ADDR) || (io_addr == KBC_AUX_ADDR)
                     || (io_addr == KBC_CMD_ADDR);

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            kbc_select_n <= 1'b1;
            irq1_q <= 1'b0;
        end else begin
            kbc_select_n <= !(kbc_hit && (!io_read_n || !io_write_n));
            irq1_q <= kbc_output_full;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            a20_clamp_n <= 1'b1;
            cpu_reset_out <= 1'b0;
        end else begin
            a20_clamp_n <= kbc_a20_clamp_n && !fast_q[FP_A20];
            cpu_reset_out <= kbc_cpu_reset || rif.fire;
        end
    end

    // Read side; the RTC index port is write-only and never answers
    always_comb begin
        rd_mux = '0;
        rd_hit = 1'b0;
        if (io_addr == NMI_STAT_ADDR) begin
            rd_hit = 1'b1;
            rd_mux[ST_PAR_DIS] = par_dis_q;
            rd_mux[ST_CHK_DIS] = chk_dis_q;
            rd_mux[ST_REFRESH] = refresh_q;
            rd_mux[ST_TIMER2] = timer2_out;
            rd_mux[ST_CHK_FLAG] = chk_flag;
            rd_mux[ST_PAR_FLAG] = par_flag;
        end else if (io_addr == FAST_PORT_ADDR && fast_port_enable) begin
            rd_hit = 1'b1;
            rd_mux[FP_RESET] = fast_q[FP_RESET];
            rd_mux[FP_A20] = fast_q[FP_A20];
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            io_rdata_q <= '0;
            io_rdata_oe_q <= 1'b0;
        end else begin
            io_rdata_q <= (!io_read_n && rd_hit) ? rd_mux : '0;
            io_rdata_oe_q <= !io_read_n && rd_hit;
        end
    end

    a_kbc_select: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        (!(io_read_n && io_write_n) && io_addr == KBC_CMD_ADDR)
        |=> !kbc_select_n)
        else $error("keyboard select missing on port 64h access");
    a_kbc_idle: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        (io_read_n && io_write_n) |=> kbc_select_n)
        else $error("keyboard select without an access");
    a_irq1_follow: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        ##1 irq1_q == $past(kbc_output_full))
        else $error("IRQ1 does not follow keyboard output full");
    a_kbc_reset: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        kbc_cpu_reset |=> cpu_reset_out)
        else $error("keyboard reset request not passed to the CPU");
    a_a20_clamp: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        (fast_q[FP_A20] || !kbc_a20_clamp_n) |=> !a20_clamp_n)
        else $error("A20 clamp not driven low");
    a_a20_release: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        (!fast_q[FP_A20] && kbc_a20_clamp_n) |=> a20_clamp_n)
        else $error("A20 clamp held low with no source");
    a_par_dis_wr: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        wr_stat |=> par_dis_q == $past(wr_data_q[ST_PAR_DIS]))
        else $error("parity disable bit not written");
    a_chk_dis_wr: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        wr_stat |=> chk_dis_q == $past(wr_data_q[ST_CHK_DIS]))
        else $error("channel check disable bit not written");
    a_timer2_read: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        (!io_read_n && io_addr == NMI_STAT_ADDR)
        |=> io_rdata_q[ST_TIMER2] == $past(timer2_out))
        else $error("status read misses timer 2 level");
    a_rtc_index: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        wr_rtc |=> rtc_index_q == $past(wr_data_q[RTC_IDX_MSB:0]))
        else $error("RTC index not taken from write");
    a_nmi_mask_wr: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        wr_rtc |=> nmi_blk_q == $past(wr_data_q[RTC_NMI_BLK]))
        else $error("NMI mask not taken from write");
    a_nmi_masked: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        nmi_blk_q |=> !nmi_out_q)
        else $error("NMI raised while masked");
    a_nmi_raise: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        (!nmi_blk_q && (chk_flag || par_flag)) |=> nmi_out_q)
        else $error("NMI missing for latched error");
    a_rtc_no_read: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        (!io_read_n && io_addr == RTC_IDX_ADDR) |=> !io_rdata_oe_q)
        else $error("write-only RTC index port answered a read");
    a_reset_delay: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        rif.trig |-> !cpu_reset_out[*2] ##A_DLY rif.fire
        ##1 cpu_reset_out)
        else $error("fast reset pulse not at programmed delay");
    a_refresh_bit: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        refresh_cycle |=> refresh_q != $past(refresh_q))
        else $error("refresh bit did not toggle");
    a_ro_status: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        (wr_stat && !refresh_cycle) |=> $stable(refresh_q))
        else $error("write disturbed refresh bit");
    a_fast_gate: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        (!fast_port_enable && wr_commit) |=> $stable(fast_q))
        else $error("fast port written while disabled");
    a_fast_off_read: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        (!io_read_n && io_addr == FAST_PORT_ADDR && !fast_port_enable)
        |=> !io_rdata_oe_q)
        else $error("disabled fast port answered a read");
    a_fast_store: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        wr_fast |=> fast_q == $past({wr_data_q[FP_A20], wr_data_q[FP_RESET]}))
        else $error("fast port bits not taken from write");
    a_fast_keep: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        (fast_q[FP_RESET] && !wr_fast) |=> fast_q[FP_RESET])
        else $error("fast reset bit lost without a write");
    a_fast_upper: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        (!io_read_n && io_addr == FAST_PORT_ADDR && fast_port_enable)
        |=> (io_rdata_oe_q && io_rdata_q[DW-1:FP_A20+1] == '0))
        else $error("fast port reserved bits read nonzero");
    a_one_pulse: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        (wr_fast && fast_q[FP_RESET]) |-> !rif.trig)
        else $error("second pulse without clearing reset bit");
endmodule

/* File: atsc_kbc_model.sv */
// Keyboard controller stand-in on the far side of the glue logic
module atsc_kbc_model (
    input wire logic clk_sys,
    input wire logic kbc_select_n,
    output logic kbc_output_full,
    output logic kbc_a20_clamp_n,
    output logic kbc_cpu_reset
);
    timeunit 1ns;
    timeprecision 1ps;
    int sel_cyc = 0;
    initial begin
        kbc_output_full = 1'b0;
        kbc_a20_clamp_n = 1'b1;
        kbc_cpu_reset = 1'b0;
    end
    // Counts selected cycles so the bench can see each access once
    always @(posedge clk_sys) begin
        if (kbc_select_n === 1'b0) begin
            sel_cyc <= sel_cyc + 1;
        end
    end
    task automatic set(input logic f, input logic a, input logic r);
        @(posedge clk_sys);
        #10;
        kbc_output_full = f;
        kbc_a20_clamp_n = a;
        kbc_cpu_reset = r;
    endtask
endmodule

/* File: atsc_ports_test.sv */
// Self-checking bench for the AT system control ports
module atsc_ports_test
    import atsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, rstn, io_write_n, io_read_n;
    logic [15:0] io_addr;
    logic [7:0] io_wdata, io_rdata_q;
    logic io_rdata_oe_q, fast_port_enable, parity_check_override;
    logic parity_error_in_n, channel_check_in_n, refresh_cycle, timer2_out;
    logic kbc_output_full, kbc_a20_clamp_n, kbc_cpu_reset, kbc_select_n;
    logic irq1_q, a20_clamp_n, cpu_reset_out, nmi_out_q;
    logic [6:0] rtc_index_q, idx;
    int fails = 0, samples_checked = 0;
    int m_pdis, m_cdis, m_ref, m_cf, m_pf, m_mask, n, k, hi, first;
    localparam logic [15:0] KBC_ADDRS [3] = '{KBC_DATA_ADDR, KBC_AUX_ADDR,
                                              KBC_CMD_ADDR};

    atsc_ports dut (.clk_sys, .rstn, .io_addr, .io_wdata, .io_write_n,
        .io_read_n, .io_rdata_q, .io_rdata_oe_q, .fast_port_enable,
        .parity_check_override, .parity_error_in_n, .channel_check_in_n,
        .refresh_cycle, .timer2_out, .kbc_output_full, .kbc_a20_clamp_n,
        .kbc_cpu_reset, .kbc_select_n, .irq1_q, .a20_clamp_n,
        .cpu_reset_out, .nmi_out_q, .rtc_index_q);
    atsc_kbc_model kbc (.clk_sys, .kbc_select_n, .kbc_output_full,
        .kbc_a20_clamp_n, .kbc_cpu_reset);

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int c);
        repeat (c) @(posedge clk_sys);
        #10;
    endtask
    // Address and data held until the edge that sees the strobe high
    task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        #10;
        io_addr = a;
        io_wdata = d;
        io_write_n = 1'b0;
        cyc(1);
        io_write_n = 1'b1;
        cyc(1);
        io_addr = 16'h0080;
    endtask
    task automatic io_rd(input logic [15:0] a, input logic [7:0] e,
                         input logic oe);
        @(posedge clk_sys);
        #10;
        io_addr = a;
        io_read_n = 1'b0;
        cyc(1);
        chk("read data", e, io_rdata_q);
        chk("read enable", 8'(oe), 8'(io_rdata_oe_q));
        io_read_n = 1'b1;
        io_addr = 16'h0080;
    endtask
    function automatic logic [7:0] st_exp();
        return {m_pf[0], m_cf[0], timer2_out, m_ref[0], m_cdis[0],
                m_pdis[0], 2'b00};
    endfunction
    task automatic wr61(input logic [7:0] d);
        io_wr(NMI_STAT_ADDR, d);
        m_pdis = d[2];
        m_cdis = d[3];
        if (m_cdis != 0) m_cf = 0;
        if (m_pdis != 0 || parity_check_override) m_pf = 0;
    endtask
    task automatic wr70(input logic [7:0] d);
        io_wr(RTC_IDX_ADDR, d);
        m_mask = d[7];
        cyc(2);
        chk("rtc index", 8'(d[6:0]), 8'(rtc_index_q));
        chk("nmi", 8'(m_mask == 0 && (m_cf | m_pf) != 0),
            8'(nmi_out_q));
    endtask
    task automatic pulse(input logic [7:0] d, input int ef, input int eh);
        io_wr(FAST_PORT_ADDR, d);
        first = 0;
        hi = 0;
        for (k = 1; k <= 80; k++) begin
            cyc(1);
            if (cpu_reset_out === 1'b1) begin
                hi++;
                if (first == 0) first = k;
            end
        end
        chk("pulse start", 8'(ef), first[7:0]);
        chk("pulse width", 8'(eh), hi[7:0]);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        #2000000;
        fails++;
        finish_test();
    end

    initial begin
        io_addr = 16'h0080;
        io_wdata = 8'h00;
        io_write_n = 1'b1;
        io_read_n = 1'b1;
        fast_port_enable = 1'b1;
        parity_check_override = 1'b0;
        parity_error_in_n = 1'b1;
        channel_check_in_n = 1'b1;
        refresh_cycle = 1'b0;
        timer2_out = 1'b0;
        rstn = 1'b0;
        n = $urandom(32'h0c2f);
        {m_pdis, m_cdis, m_ref, m_cf, m_pf} = '0;
        m_mask = 1;
        repeat (3) @(posedge clk_sys);
        #10;
        rstn = 1'b1;
        cyc(1);
        chk("nmi", 8'h00, 8'(nmi_out_q));
        io_rd(FAST_PORT_ADDR, FAST_PORT_RST, 1'b1);
        io_rd(NMI_STAT_ADDR, st_exp(), 1'b1);
        io_rd(RTC_IDX_ADDR, 8'h00, 1'b0);
        io_rd(16'h0080, 8'h00, 1'b0);
        $display("test reset done");

        foreach (KBC_ADDRS[i]) begin
            n = kbc.sel_cyc;
            io_wr(KBC_ADDRS[i], 8'(i));
            chk("kbc select", 8'h01, 8'(kbc.sel_cyc - n));
        end
        for (int i = 0; i < 8; i++) begin
            kbc.set(i[0], i[1], i[2]);
            cyc(2);
            chk("irq1", 8'(i[0]), 8'(irq1_q));
            chk("a20", 8'(i[1]), 8'(a20_clamp_n));
            chk("cpu reset", 8'(i[2]), 8'(cpu_reset_out));
        end
        kbc.set(1'b0, 1'b1, 1'b0);
        $display("test kbc glue done");

        timer2_out = 1'($urandom);
        n = $urandom_range(1, 9);
        repeat (n) begin
            cyc(1);
            refresh_cycle = 1'b1;
            cyc(1);
            refresh_cycle = 1'b0;
        end
        m_ref += n;
        wr61(8'hff);
        io_rd(NMI_STAT_ADDR, st_exp(), 1'b1);
        wr61(8'h00);
        io_rd(NMI_STAT_ADDR, st_exp(), 1'b1);
        $display("test status port done");

        channel_check_in_n = 1'b0;
        cyc(1);
        channel_check_in_n = 1'b1;
        m_cf = 1;
        io_rd(NMI_STAT_ADDR, st_exp(), 1'b1);
        idx = 7'($urandom);
        wr70({1'b0, idx});
        wr70({1'b1, ~idx});
        wr70(8'h00);
        parity_check_override = 1'b1;
        parity_error_in_n = 1'b0;
        cyc(2);
        parity_error_in_n = 1'b1;
        parity_check_override = 1'b0;
        io_rd(NMI_STAT_ADDR, st_exp(), 1'b1);
        parity_error_in_n = 1'b0;
        cyc(1);
        parity_error_in_n = 1'b1;
        m_pf = 1;
        io_rd(NMI_STAT_ADDR, st_exp(), 1'b1);
        wr61(8'h08);
        wr70(8'h00);
        wr61(8'h04);
        wr70(8'h00);
        io_rd(NMI_STAT_ADDR, st_exp(), 1'b1);
        wr61(8'h00);
        $display("test nmi sources done");

        io_wr(FAST_PORT_ADDR, 8'h02);
        cyc(1);
        chk("a20", 8'h00, 8'(a20_clamp_n));
        io_rd(FAST_PORT_ADDR, 8'h02, 1'b1);
        pulse(8'hfd, 68, 1);
        chk("a20", 8'h01, 8'(a20_clamp_n));
        io_rd(FAST_PORT_ADDR, 8'h01, 1'b1);
        pulse(8'h01, 0, 0);
        pulse(8'h00, 0, 0);
        pulse(8'h01, 68, 1);
        fast_port_enable = 1'b0;
        io_wr(FAST_PORT_ADDR, 8'h02);
        cyc(1);
        chk("a20", 8'h01, 8'(a20_clamp_n));
        io_rd(FAST_PORT_ADDR, 8'h00, 1'b0);
        fast_port_enable = 1'b1;
        io_rd(FAST_PORT_ADDR, 8'h01, 1'b1);
        $display("test fast port done");
        finish_test();
    end
endmodule
